// File: core/rbmc_pkg.sv
// Purpose: Shared types and constants for the reset and boot mode control block
// Assumes: One 10 MHz clock; power-on reset arrives as an asynchronous active-high input
// Notes: Constants and types only; the logic sits in the top module
// Operation
// - External reset held low keeps the chip, apart from the debug domain, initialised and in reset.
// - Internal reset releases on the clock after a fixed count following removal.
// - Device reset alone leaves debug module state untouched.
// - Power-on reset asserts internal reset regardless of the external input.
// - Reset pin pull-up is on by default, off once its disable bit is set.
// - Reset output pin follows internal reset state, power-on and external alike.
// - High boot strap selects external boot only when flash is unsecured.
// - Default is internal flash boot; memory mode strap depends on boot and security.
// - System clock may come from crystal, ceramic resonator or external clock.
// - At reset mode B takes unsecured state, mode A the strap, secured forces zero.
// - Mode B loads at reset and also takes writes; writes never change flash security.
package rbmc_pkg;

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RELEASE_CYCLES = 8'h10;

  // Pin synchroniser indexes
  localparam int SYN_RST = 0;
  localparam int SYN_TRST = 1;
  localparam int SYN_BOOT = 2;
  localparam int SYN_MEM = 3;
  localparam int SYN_N = 4;

  typedef enum logic [1:0] {
    RBMC_HOLD,
    RBMC_COUNT,
    RBMC_RUN
  } rbmc_phase_t;

  typedef enum logic [1:0] {
    RBMC_SRC_CERAMIC,
    RBMC_SRC_CRYSTAL,
    RBMC_SRC_EXTERNAL
  } rbmc_clk_src_t;

  typedef struct packed {
    logic reset_pin;
    logic boot_strap;
    logic mem_strap;
  } rbmc_pud_t;

  typedef struct packed {
    logic mode_bit_b;
    logic mode_bit_a;
  } rbmc_opmode_t;

  typedef struct packed {
    logic [SYN_N-1:0][2:0] sync;
    logic [SYN_N-1:0] stable;
    rbmc_phase_t phase;
    logic [CNT_W-1:0] count;
    logic sys_reset;
    logic reset_out;
    logic debug_reset;
    rbmc_pud_t pud;
    rbmc_opmode_t opmode;
    logic secured_at_reset;
    logic ext_mem_mode;
    rbmc_clk_src_t clk_src;
  } rbmc_state_t;

  localparam rbmc_pud_t PUD_RESET = '{reset_pin: 1'b0, boot_strap: 1'b0, mem_strap: 1'b0};
  localparam rbmc_opmode_t OPMODE_RESET = '{mode_bit_b: 1'b0, mode_bit_a: 1'b0};

  localparam rbmc_state_t STATE_RESET = '{
    sync: '0,
    stable: '0,
    phase: RBMC_HOLD,
    count: '0,
    sys_reset: 1'b1,
    reset_out: 1'b1,
    debug_reset: 1'b1,
    pud: PUD_RESET,
    opmode: OPMODE_RESET,
    secured_at_reset: 1'b1,
    ext_mem_mode: 1'b0,
    clk_src: RBMC_SRC_CERAMIC
  };

endpackage : rbmc_pkg

// File: core/rbmc_top.sv
// Purpose: Chip reset sequencing, reset output, pull-up control and boot mode capture
// Assumes: rst is the power-on reset; pins are asynchronous to sys_clk
// Notes: flash_secured and the write strobes come from logic on sys_clk
`timescale 1ns/10ps
module rbmc_top #(
  parameter logic [rbmc_pkg::CNT_W-1:0] RELEASE_CYCLES = rbmc_pkg::RELEASE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic test_reset_n_pin,
  input wire logic external_boot_strap,
  input wire logic ext_memory_mode_strap,
  input wire logic flash_secured,
  input wire logic pud_wr,
  input wire rbmc_pkg::rbmc_pud_t pud_wdata,
  input wire logic opmode_wr,
  input wire rbmc_pkg::rbmc_opmode_t opmode_wdata,
  input wire logic clk_src_wr,
  input wire rbmc_pkg::rbmc_clk_src_t clk_src_wdata,
  output logic sys_reset,
  output logic reset_out_pin,
  output logic debug_reset,
  output rbmc_pkg::rbmc_pud_t pullup_disable_register,
  output logic reset_pullup_en,
  output logic boot_pullup_en,
  output logic mem_pullup_en,
  output rbmc_pkg::rbmc_opmode_t operating_mode_register,
  output logic ext_boot_active,
  output logic ext_mem_mode,
  output rbmc_pkg::rbmc_clk_src_t clk_source
);

  rbmc_pkg::rbmc_state_t st;
  rbmc_pkg::rbmc_state_t next_st;
  logic [rbmc_pkg::SYN_N-1:0] pins;

  assign pins = {ext_memory_mode_strap, external_boot_strap, test_reset_n_pin, reset_n_pin};

  always_comb begin
    next_st = st;
    // Three stages; a change is taken only once stages two and three agree
    for (int i = 0; i < rbmc_pkg::SYN_N; i++) begin
      next_st.sync[i] = {st.sync[i][1:0], pins[i]};
      if (st.sync[i][1] == st.sync[i][2]) begin
        next_st.stable[i] = st.sync[i][2];
      end
    end

    case (st.phase)
      rbmc_pkg::RBMC_HOLD: begin
        next_st.count = '0;
        next_st.sys_reset = 1'b1;
        if (st.stable[rbmc_pkg::SYN_RST]) begin
          next_st.phase = rbmc_pkg::RBMC_COUNT;
        end
      end
      rbmc_pkg::RBMC_COUNT: begin
        if (!st.stable[rbmc_pkg::SYN_RST]) begin
          next_st.phase = rbmc_pkg::RBMC_HOLD;
          next_st.count = '0;
        end else if (st.count == RELEASE_CYCLES - 1'b1) begin
          next_st.phase = rbmc_pkg::RBMC_RUN;
          next_st.sys_reset = 1'b0;
          // Boot mode is captured here; before the next reset only opmode writes change it, mode A only if unsecured at reset
          next_st.secured_at_reset = flash_secured;
          next_st.opmode.mode_bit_b = !flash_secured;
          next_st.opmode.mode_bit_a = st.stable[rbmc_pkg::SYN_BOOT] && !flash_secured;
          next_st.ext_mem_mode = st.stable[rbmc_pkg::SYN_MEM] && st.stable[rbmc_pkg::SYN_BOOT]
            && !flash_secured;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      rbmc_pkg::RBMC_RUN: begin
        if (!st.stable[rbmc_pkg::SYN_RST]) begin
          next_st.phase = rbmc_pkg::RBMC_HOLD;
          next_st.sys_reset = 1'b1;
        end
      end
      default: begin
        next_st.phase = rbmc_pkg::RBMC_HOLD;
        next_st.sys_reset = 1'b1;
      end
    endcase

    // A reset in progress reinitialises software-visible state
    if (next_st.sys_reset && st.phase != rbmc_pkg::RBMC_COUNT) begin
      next_st.pud = rbmc_pkg::PUD_RESET;
      next_st.clk_src = rbmc_pkg::RBMC_SRC_CERAMIC;
      next_st.opmode = rbmc_pkg::OPMODE_RESET;
      next_st.ext_mem_mode = 1'b0;
    end else if (!st.sys_reset) begin
      if (pud_wr) begin
        next_st.pud = pud_wdata;
      end
      if (clk_src_wr) begin
        next_st.clk_src = clk_src_wdata;
      end
      if (opmode_wr) begin
        // Mode B is stored but steers nothing, so security cannot be changed from here
        next_st.opmode.mode_bit_b = opmode_wdata.mode_bit_b;
        if (!st.secured_at_reset) begin
          next_st.opmode.mode_bit_a = opmode_wdata.mode_bit_a;
        end
      end
    end

    next_st.reset_out = next_st.sys_reset;
    // Only test reset or power-on touches the debug domain
    next_st.debug_reset = !st.stable[rbmc_pkg::SYN_TRST];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= rbmc_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign sys_reset = st.sys_reset;
  assign reset_out_pin = st.reset_out;
  assign debug_reset = st.debug_reset;
  assign pullup_disable_register = st.pud;
  assign reset_pullup_en = !st.pud.reset_pin;
  assign boot_pullup_en = !st.pud.boot_strap;
  assign mem_pullup_en = !st.pud.mem_strap;
  assign operating_mode_register = st.opmode;
  assign ext_boot_active = st.opmode.mode_bit_a;
  assign ext_mem_mode = st.ext_mem_mode;
  assign clk_source = st.clk_src;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  hold_in_reset_a: assert property (
    !st.stable[rbmc_pkg::SYN_RST] |=> sys_reset [*2])
    else $error("internal reset not held while external reset low");

  release_count_a: assert property (
    $fell(sys_reset) |-> $past(st.count) == RELEASE_CYCLES - 1'b1 && $past(st.stable[rbmc_pkg::SYN_RST]))
    else $error("internal reset released at wrong count");

  debug_kept_a: assert property (
    $rose(sys_reset) && st.stable[rbmc_pkg::SYN_TRST] && $past(st.stable[rbmc_pkg::SYN_TRST])
      |-> !debug_reset)
    else $error("device reset disturbed debug domain");

  power_on_a: assert property (
    $past(rst) |-> sys_reset && reset_out_pin && debug_reset)
    else $error("power-on reset not asserted");

  pullup_off_a: assert property (
    pud_wr && pud_wdata.reset_pin && !sys_reset |=> !reset_pullup_en)
    else $error("reset pin pull-up not turned off");

  reset_out_a: assert property (
    $rose(st.phase == rbmc_pkg::RBMC_HOLD) |-> reset_out_pin ##1 reset_out_pin)
    else $error("reset output does not follow internal reset");

  boot_mode_a: assert property (
    $fell(sys_reset) |-> ext_boot_active == ($past(st.stable[rbmc_pkg::SYN_BOOT]) && !$past(flash_secured)))
    else $error("boot mode captured wrongly");

  mode_b_load_a: assert property (
    $fell(sys_reset) |-> operating_mode_register.mode_bit_b == !$past(flash_secured))
    else $error("mode bit B not loaded from flash security");

  // A reset arriving with the pin low clears mode B, so only a held-off input counts here
  mode_b_hold_a: assert property (
    !sys_reset && !$past(sys_reset) && !opmode_wr && st.stable[rbmc_pkg::SYN_RST]
      |=> $stable(operating_mode_register.mode_bit_b))
    else $error("mode bit B changed outside reset");

  // Software may clear mode A later, so memory mode is judged only where it is set
  mem_mode_a: assert property (
    $rose(ext_mem_mode) |-> $fell(sys_reset) && ext_boot_active && $past(st.stable[rbmc_pkg::SYN_MEM]))
    else $error("memory mode set outside an external boot release");

  reset_clears_a: assert property (
    sys_reset |-> pullup_disable_register == rbmc_pkg::PUD_RESET && clk_source == rbmc_pkg::RBMC_SRC_CERAMIC
      && operating_mode_register == rbmc_pkg::OPMODE_RESET && !ext_mem_mode)
    else $error("state not initialised during reset");

  release_wait_a: assert property (
    st.phase != rbmc_pkg::RBMC_RUN |-> sys_reset)
    else $error("internal reset dropped before the count ended");

  count_bound_a: assert property (
    st.phase == rbmc_pkg::RBMC_COUNT |-> st.count < RELEASE_CYCLES)
    else $error("release counter ran past its end");

  test_reset_a: assert property (
    !st.stable[rbmc_pkg::SYN_TRST] |=> debug_reset)
    else $error("debug reset missing while test reset held");

  pullup_default_a: assert property (
    sys_reset |-> reset_pullup_en && boot_pullup_en && mem_pullup_en)
    else $error("pull-ups not on during reset");

  reset_mirror_a: assert property (
    reset_out_pin == sys_reset)
    else $error("reset output differs from internal reset");

  secured_boot_a: assert property (
    !sys_reset && st.secured_at_reset |-> !ext_boot_active)
    else $error("external boot active with secured flash");

  // Writes that meet an incoming reset are dropped, so those cycles are left out
  mode_a_write_a: assert property (
    opmode_wr && !sys_reset && !st.secured_at_reset && st.stable[rbmc_pkg::SYN_RST]
      |=> ext_boot_active == $past(opmode_wdata.mode_bit_a))
    else $error("mode bit A write not taken");

  clk_src_write_a: assert property (
    clk_src_wr && !sys_reset && st.stable[rbmc_pkg::SYN_RST] |=> clk_source == $past(clk_src_wdata))
    else $error("clock source write not taken");

  sync_agree_a: assert property (
    $changed(st.stable[rbmc_pkg::SYN_RST])
      |-> $past(st.sync[rbmc_pkg::SYN_RST][1]) == $past(st.sync[rbmc_pkg::SYN_RST][2])
      && st.stable[rbmc_pkg::SYN_RST] == $past(st.sync[rbmc_pkg::SYN_RST][2]))
    else $error("reset input taken before the synchroniser agreed");

  release_c: cover property ($fell(sys_reset) ##[1:50] $rose(sys_reset));
  ext_boot_c: cover property ($fell(sys_reset) && ext_boot_active);
  secured_c: cover property ($fell(sys_reset) && !ext_boot_active && $past(st.stable[rbmc_pkg::SYN_BOOT]));
  debug_only_c: cover property (debug_reset && !sys_reset);
  int_boot_c: cover property ($fell(sys_reset) && !ext_boot_active && operating_mode_register.mode_bit_b);

endmodule : rbmc_top

// File: testbench/rbmc_board.sv
// Purpose: Board-side model driving the reset and test reset pins
// Assumes: Requests change at the falling edge
// Notes: Test reset follows only a full reset request
`timescale 1ns/10ps
module rbmc_board (
  input wire logic sys_clk,
  input wire logic full_req,
  input wire logic dev_req,
  output logic reset_n_pin,
  output logic test_reset_n_pin
);
  initial begin
    reset_n_pin = 1'b1;
    test_reset_n_pin = 1'b1;
  end
  // Both pins move on one edge so the debug side never sees a split reset
  always @(negedge sys_clk) begin
    reset_n_pin <= !(full_req || dev_req);
    test_reset_n_pin <= !full_req;
  end
endmodule : rbmc_board

// File: testbench/reset_and_boot_mode_control_tb_top.sv
// Purpose: Self-checking bench for reset release, boot capture and pull-up bits
// Assumes: Inputs change at the falling edge
// Notes: Release count shortened to keep the run brief
`timescale 1ns/10ps
module reset_and_boot_mode_control_tb_top;
  localparam int RC = 2;
  logic sys_clk = 1'b0, rst = 1'b1, full_req = 1'b0, dev_req = 1'b0;
  logic reset_n_pin, test_reset_n_pin, boot = 1'b1, mem_strap = 1'b1, flash_secured = 1'b0;
  logic pud_wr = 1'b0, opmode_wr = 1'b0, clk_src_wr = 1'b0;
  rbmc_pkg::rbmc_pud_t pud_wdata = '0;
  rbmc_pkg::rbmc_opmode_t opmode_wdata = '0;
  rbmc_pkg::rbmc_clk_src_t clk_src_wdata = rbmc_pkg::RBMC_SRC_CERAMIC;
  logic sys_reset, reset_out_pin, debug_reset, rpe, bpe, mpe, ext_boot_active, ext_mem_mode;
  rbmc_pkg::rbmc_pud_t pud;
  rbmc_pkg::rbmc_opmode_t opmode;
  rbmc_pkg::rbmc_clk_src_t clk_source;
  int failures = 0, n_tests = 0, n;

  always #50 sys_clk = ~sys_clk;

  rbmc_board rbmc_board_inst (.sys_clk(sys_clk), .full_req(full_req), .dev_req(dev_req),
    .reset_n_pin(reset_n_pin), .test_reset_n_pin(test_reset_n_pin));

  rbmc_top #(.RELEASE_CYCLES(8'(RC))) rbmc_top_inst (.sys_clk(sys_clk), .rst(rst),
    .reset_n_pin(reset_n_pin), .test_reset_n_pin(test_reset_n_pin), .external_boot_strap(boot),
    .ext_memory_mode_strap(mem_strap), .flash_secured(flash_secured), .pud_wr(pud_wr), .pud_wdata(pud_wdata),
    .opmode_wr(opmode_wr), .opmode_wdata(opmode_wdata), .clk_src_wr(clk_src_wr), .clk_src_wdata(clk_src_wdata),
    .sys_reset(sys_reset), .reset_out_pin(reset_out_pin), .debug_reset(debug_reset),
    .pullup_disable_register(pud), .reset_pullup_en(rpe), .boot_pullup_en(bpe), .mem_pullup_en(mpe),
    .operating_mode_register(opmode), .ext_boot_active(ext_boot_active), .ext_mem_mode(ext_mem_mode),
    .clk_source(clk_source));

  task check(input logic [2:0] seen, input logic [2:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task close_out;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Counts falling edges until internal reset drops, bounded so a stuck reset cannot hang
  task wait_rel;
    n = 0;
    while (sys_reset !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check(3'(n >= RC + 4 && n <= RC + 6), 3'h1);
  endtask : wait_rel

  task wait_rst;
    repeat (10) @(negedge sys_clk);
  endtask : wait_rst

  task t_power;
    repeat (3) @(negedge sys_clk);
    check({sys_reset, reset_out_pin, debug_reset}, 3'h7);
    check({rpe, bpe, mpe}, 3'h7);
    check(3'(clk_source), 3'h0);
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    wait_rel();
    check({reset_out_pin, debug_reset}, 3'h0);
    check({opmode, ext_boot_active}, 3'h7);
    check(3'(ext_mem_mode), 3'h1);
  endtask : t_power

  task t_dev;
    dev_req = 1'b1;
    wait_rst();
    check({sys_reset, reset_out_pin, debug_reset}, 3'h6);
    pud_wdata = 3'h7;
    pud_wr = 1'b1;
    @(negedge sys_clk);
    pud_wr = 1'b0;
    @(negedge sys_clk);
    check(pud, 3'h0);
    dev_req = 1'b0;
    wait_rel();
  endtask : t_dev

  task t_secure;
    flash_secured = 1'b1;
    full_req = 1'b1;
    wait_rst();
    check({sys_reset, debug_reset}, 3'h3);
    full_req = 1'b0;
    wait_rel();
    check({opmode, ext_boot_active}, 3'h0);
    check(3'(ext_mem_mode), 3'h0);
    opmode_wdata = 2'h1;
    opmode_wr = 1'b1;
    @(negedge sys_clk);
    opmode_wr = 1'b0;
    flash_secured = 1'b0;
    wait_rst();
    check(3'(opmode), 3'h0);
  endtask : t_secure

  // Both straps low: internal boot with unsecured flash, then boot software turns off the strap pull-ups
  task t_boot;
    boot = 1'b0;
    mem_strap = 1'b0;
    full_req = 1'b1;
    wait_rst();
    full_req = 1'b0;
    wait_rel();
    check({opmode, ext_boot_active}, 3'h4);
    check(3'(ext_mem_mode), 3'h0);
    check(3'(clk_source), 3'h0);
    check({rpe, bpe, mpe}, 3'h7);
    pud_wdata = 3'h3;
    pud_wr = 1'b1;
    @(negedge sys_clk);
    pud_wr = 1'b0;
    @(negedge sys_clk);
    check({rpe, bpe, mpe}, 3'h4);
    opmode_wdata = 2'h3;
    opmode_wr = 1'b1;
    @(negedge sys_clk);
    opmode_wr = 1'b0;
    @(negedge sys_clk);
    check({opmode, ext_boot_active}, 3'h7);
  endtask : t_boot

  task t_regs;
    for (int i = 0; i < 3; i++) begin
      pud_wdata = 3'(1 << i);
      pud_wr = 1'b1;
      @(negedge sys_clk);
      pud_wr = 1'b0;
      @(negedge sys_clk);
      check(pud, 3'(1 << i));
      check({rpe, bpe, mpe}, ~3'(1 << i));
    end
    for (int i = 0; i < 3; i++) begin
      clk_src_wdata = rbmc_pkg::rbmc_clk_src_t'(i);
      clk_src_wr = 1'b1;
      @(negedge sys_clk);
      clk_src_wr = 1'b0;
      @(negedge sys_clk);
      check(3'(clk_source), 3'(i));
    end
  endtask : t_regs

  initial begin
    t_power();
    t_dev();
    t_secure();
    t_regs();
    t_boot();
    close_out();
  end

  // Whole run needs about a hundred cycles; this leaves a wide margin
  initial begin
    #(3000 * 100);
    failures++;
    close_out();
  end
endmodule : reset_and_boot_mode_control_tb_top
